// ### core/ufc_top.sv
module ufc_top (
    input  wire logic       I_CLK,
    input  wire logic       I_RESET,
    input  wire logic [7:0] I_DIVISOR_HIGH_BYTE,
    input  wire logic [7:0] I_DIVISOR_LOW_BYTE,
    input  wire logic       I_PRESCALE_BYPASS_BIT,
    input  wire logic       I_PORT_ENABLE,
    input  wire logic [1:0] I_WORD_LEN,
    input  wire logic       I_TWO_STOP,
    input  wire logic       I_PARITY_EN,
    input  wire logic       I_PARITY_EVEN,
    input  wire logic       I_INFRARED_EN,
    input  wire logic       I_FLOW_EN,
    input  wire logic       I_TX_IRQ_EN,
    input  wire logic       I_RX_IRQ_EN,
    input  wire logic       I_DMA_MODE,
    input  wire logic       I_TX_WRITE,
    input  wire logic [7:0] I_TX_DATA,
    input  wire logic       I_RX_READ,
    input  wire logic       I_RXD,
    input  wire logic       I_CTS_N,
    output logic            O_TXD,
    output logic            O_RTS_N,
    output logic            O_RXD_TIMER,
    output logic [7:0]      O_RX_DATA,
    output logic            O_RX_VALID,
    output logic            O_RX_PARITY_ERR,
    output logic            O_RX_FRAME_ERR,
    output logic            O_RX_OVERRUN,
    output logic            O_TX_ROOM,
    output logic            O_TX_IRQ,
    output logic            O_RX_IRQ,
    output logic            O_TX_DMA_REQ,
    output logic            O_RX_DMA_REQ
);
    // ****************************************
    // bit clock
    // ****************************************
    logic tick;
    logic bit_tick;
    logic [15:0] divisor;
    assign divisor = {I_DIVISOR_HIGH_BYTE, I_DIVISOR_LOW_BYTE};
    ufc_tick u_tick (
        .i_clk      (I_CLK),
        .i_reset    (I_RESET),
        .i_divisor  (divisor),
        .i_bypass   (I_PRESCALE_BYPASS_BIT),
        .o_tick     (tick),
        .o_bit_tick (bit_tick)
    );

    function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic ev);
        logic p;
        p = ~ev;
        for (int k = 0; k < 8; k++)
            if (k < n)
                p = p ^ d[k];
        return p;
    endfunction

    logic [3:0] nbits;
    assign nbits = ufc_pkg::BITS_BASE + {2'h0, I_WORD_LEN};

    // ****************************************
    // transmitter
    // ****************************************
    ufc_pkg::ufc_state_type tst_r, tst_nxt;
    logic [7:0] thold_r, thold_nxt, tsh_r, tsh_nxt;
    logic       thv_r, thv_nxt, tline_r, tline_nxt, tstop2_r, tstop2_nxt;
    logic [3:0] tcnt_r, tcnt_nxt, tir_r, tir_nxt;
    logic       txd_nxt, tirq_nxt, tdma_nxt, room_nxt;
    // parity is latched at load, since the holding buffer may refill mid-frame
    logic       tpar_r, tpar_nxt;
    always_comb begin
        tst_nxt = tst_r; thold_nxt = thold_r; tsh_nxt = tsh_r; thv_nxt = thv_r;
        tpar_nxt = tpar_r;
        tline_nxt = tline_r; tstop2_nxt = tstop2_r; tcnt_nxt = tcnt_r; tir_nxt = tir_r;
        if (I_TX_WRITE && !thv_r) begin
            thold_nxt = I_TX_DATA;
            thv_nxt   = 1'b1;
        end
        if (bit_tick) begin
            case (tst_r)
                ufc_pkg::ST_IDLE: begin
                    tline_nxt = 1'b1;
                    if (thv_r && I_PORT_ENABLE && !(I_FLOW_EN && I_CTS_N)) begin
                        tsh_nxt = thold_r; thv_nxt = 1'b0; tline_nxt = 1'b0;
                        tpar_nxt = par_of(thold_r, nbits, I_PARITY_EVEN);
                        tcnt_nxt = '0; tst_nxt = ufc_pkg::ST_DATA;
                    end
                end
                ufc_pkg::ST_DATA: begin
                    tline_nxt = tsh_r[0]; tsh_nxt = {1'b0, tsh_r[7:1]};
                    tcnt_nxt = tcnt_r + 4'h1;
                    if (tcnt_r + 4'h1 == nbits)
                        tst_nxt = I_PARITY_EN ? ufc_pkg::ST_PAR : ufc_pkg::ST_STOP;
                end
                ufc_pkg::ST_PAR: begin
                    tline_nxt = tpar_r;
                    tst_nxt = ufc_pkg::ST_STOP;
                end
                ufc_pkg::ST_STOP: begin
                    tline_nxt = 1'b1; tstop2_nxt = I_TWO_STOP && !tstop2_r;
                    if (!(I_TWO_STOP && !tstop2_r)) tst_nxt = ufc_pkg::ST_IDLE;
                end
                default: tst_nxt = ufc_pkg::ST_IDLE;
            endcase
        end
        if (tick && tir_r != ufc_pkg::OVS_LAST) tir_nxt = tir_r + 4'h1;
        if (bit_tick)
            tir_nxt = '0;
        txd_nxt  = I_INFRARED_EN ? !(!tline_r && tir_r < ufc_pkg::IR_PULSE) : tline_r;
        room_nxt = !thv_nxt;
        tirq_nxt = room_nxt && I_TX_IRQ_EN;
        tdma_nxt = room_nxt && I_DMA_MODE;
    end
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            tst_r <= ufc_pkg::ST_IDLE; thold_r <= '0; tsh_r <= '0; thv_r <= 1'b0;
            tline_r <= 1'b1; tstop2_r <= 1'b0; tcnt_r <= '0; tir_r <= ufc_pkg::OVS_LAST;
            tpar_r <= 1'b0;
            O_TXD <= 1'b1; O_TX_IRQ <= 1'b0; O_TX_DMA_REQ <= 1'b0; O_TX_ROOM <= 1'b1;
        end else begin
            tst_r <= tst_nxt; thold_r <= thold_nxt; tsh_r <= tsh_nxt; thv_r <= thv_nxt;
            tline_r <= tline_nxt; tstop2_r <= tstop2_nxt; tcnt_r <= tcnt_nxt;
            tpar_r <= tpar_nxt;
            tir_r <= tir_nxt; O_TXD <= txd_nxt; O_TX_IRQ <= tirq_nxt;
            O_TX_DMA_REQ <= tdma_nxt; O_TX_ROOM <= room_nxt;
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    ufc_pkg::ufc_state_type rst_r, rst_nxt;
    logic [7:0] rsh_r, rsh_nxt;
    logic [3:0] rph_r, rph_nxt, rcnt_r, rcnt_nxt;
    logic       rin, rpar_r, rpar_nxt, rstop2_r, rstop2_nxt;
    logic [7:0] buf_r [2];
    logic [7:0] buf_nxt [2];
    logic [1:0] fill_r, fill_nxt;
    logic       rdone, rperr, rferr, ovr_nxt, perr_nxt, ferr_nxt;
    logic       rts_nxt, rirq_nxt, rdma_nxt;
    logic [7:0] rword;
    assign rin = I_RXD;
    always_comb begin
        rst_nxt = rst_r; rsh_nxt = rsh_r; rph_nxt = rph_r; rcnt_nxt = rcnt_r;
        rpar_nxt = rpar_r; rstop2_nxt = rstop2_r; rdone = 1'b0; rperr = 1'b0; rferr = 1'b0;
        rword = rsh_r >> (4'h8 - nbits);
        if (tick) begin
            rph_nxt = rph_r + 4'h1;
            case (rst_r)
                ufc_pkg::ST_IDLE: begin
                    rph_nxt = '0;
                    if (!rin && I_PORT_ENABLE) rst_nxt = ufc_pkg::ST_START;
                end
                ufc_pkg::ST_START: begin
                    if (rph_r == ufc_pkg::OVS_MID || I_PRESCALE_BYPASS_BIT) begin
                        rph_nxt = '0; rcnt_nxt = '0; rpar_nxt = 1'b0;
                        rst_nxt = rin ? ufc_pkg::ST_IDLE : ufc_pkg::ST_DATA;
                    end
                end
                ufc_pkg::ST_DATA, ufc_pkg::ST_PAR, ufc_pkg::ST_STOP: begin
                    if (rph_r == ufc_pkg::OVS_LAST || I_PRESCALE_BYPASS_BIT) begin
                        rph_nxt = '0;
                        if (rst_r == ufc_pkg::ST_DATA) begin
                            rsh_nxt = {rin, rsh_r[7:1]}; rcnt_nxt = rcnt_r + 4'h1;
                            if (rcnt_r + 4'h1 == nbits)
                                rst_nxt = I_PARITY_EN ? ufc_pkg::ST_PAR : ufc_pkg::ST_STOP;
                            rstop2_nxt = 1'b0;
                        end else if (rst_r == ufc_pkg::ST_PAR) begin
                            rpar_nxt = rin; rst_nxt = ufc_pkg::ST_STOP;
                        end else begin
                            rferr = !rin;
                            rstop2_nxt = 1'b1;
                            if (!(I_TWO_STOP && !rstop2_r)) begin
                                rdone = 1'b1; rst_nxt = ufc_pkg::ST_IDLE;
                                rperr = I_PARITY_EN &&
                                        (rpar_r != par_of(rword, nbits, I_PARITY_EVEN));
                            end
                        end
                    end
                end
                default: rst_nxt = ufc_pkg::ST_IDLE;
            endcase
        end
        buf_nxt[0] = buf_r[0]; buf_nxt[1] = buf_r[1]; fill_nxt = fill_r;
        if (I_RX_READ && fill_r != 2'h0) begin
            buf_nxt[0] = buf_r[1]; fill_nxt = fill_r - 2'h1;
        end
        ovr_nxt = O_RX_OVERRUN;
        if (rdone) begin
            if (fill_nxt == 2'h2) ovr_nxt = 1'b1;
            else begin buf_nxt[fill_nxt[0]] = rword; fill_nxt = fill_nxt + 2'h1; end
        end
        perr_nxt = rdone ? rperr : O_RX_PARITY_ERR;
        ferr_nxt = rdone ? rferr : O_RX_FRAME_ERR;
        rts_nxt  = I_FLOW_EN && (fill_nxt > ufc_pkg::HIGH_WATER);
        rirq_nxt = (fill_nxt != 2'h0) && I_RX_IRQ_EN;
        rdma_nxt = (fill_nxt != 2'h0) && I_DMA_MODE;
    end
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rst_r <= ufc_pkg::ST_IDLE; rsh_r <= '0; rph_r <= '0; rcnt_r <= '0;
            rpar_r <= 1'b0; rstop2_r <= 1'b0; buf_r[0] <= '0; buf_r[1] <= '0; fill_r <= '0;
            O_RX_DATA <= '0; O_RX_VALID <= 1'b0; O_RX_OVERRUN <= 1'b0; O_RTS_N <= 1'b0;
            O_RX_PARITY_ERR <= 1'b0; O_RX_FRAME_ERR <= 1'b0; O_RX_IRQ <= 1'b0;
            O_RX_DMA_REQ <= 1'b0; O_RXD_TIMER <= 1'b1;
        end else begin
            rst_r <= rst_nxt; rsh_r <= rsh_nxt; rph_r <= rph_nxt; rcnt_r <= rcnt_nxt;
            rpar_r <= rpar_nxt; rstop2_r <= rstop2_nxt;
            buf_r[0] <= buf_nxt[0]; buf_r[1] <= buf_nxt[1]; fill_r <= fill_nxt;
            O_RX_DATA <= buf_nxt[0]; O_RX_VALID <= fill_nxt != 2'h0;
            O_RX_OVERRUN <= ovr_nxt; O_RTS_N <= rts_nxt;
            O_RX_PARITY_ERR <= perr_nxt; O_RX_FRAME_ERR <= ferr_nxt;
            O_RX_IRQ <= rirq_nxt; O_RX_DMA_REQ <= rdma_nxt;
            O_RXD_TIMER <= I_RXD;
        end
    end
endmodule // ufc_top

// ### core/ufc_pkg.sv
// How it works
// - full duplex transmit and receive, PIO or DMA
// - 5-8 data bits, 1-2 stop, parity
// - frame spans 7 to 12 bits
// - two character buffers receive, one holding buffer transmit
// - separate transmit and receive DMA requests
// - rate from clock/1048560 up to clock
// - bit clock is clock/divisor, optionally /16
// - divisor from high and low bytes
// - prescale bypass sits in global control
// - maskable transmit and receive interrupt requests
// - receive line exposed for timer autobaud
// - flow control pins only when enabled
// - deasserted clear-to-send holds new transmissions
// - request-to-send drops above high water
// - optional infrared pulse encode on transmit; receive takes the line as is
package ufc_pkg;
    // ****************************************
    // character format and timing
    // ****************************************
    localparam int          DATA_W      = 8;
    localparam int          DIV_W       = 16;
    localparam logic [3:0]  OVS_LAST    = 4'hF;
    localparam logic [3:0]  OVS_MID     = 4'h7;
    localparam logic [3:0]  IR_PULSE    = 4'h2;
    localparam logic [1:0]  HIGH_WATER  = 2'h1;
    localparam logic [1:0]  WLEN_BASE   = 2'h0;
    localparam logic [3:0]  BITS_BASE   = 4'h5;
    localparam logic [15:0] DIV_ONE     = 16'h0001;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ufc_state_type;
endpackage : ufc_pkg

// ### core/ufc_tick.sv
module ufc_tick (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_divisor,
    input  wire logic        i_bypass,
    output logic             o_tick,
    output logic             o_bit_tick
);
    logic [15:0] cnt_r, cnt_nxt;
    logic [3:0]  sub_r, sub_nxt;
    logic        tick_nxt, bit_nxt;
    always_comb begin
        tick_nxt = 1'b0;
        bit_nxt  = 1'b0;
        cnt_nxt  = cnt_r + ufc_pkg::DIV_ONE;
        sub_nxt  = sub_r;
        if (cnt_r + ufc_pkg::DIV_ONE >= i_divisor) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
            sub_nxt  = sub_r + 4'h1;
            bit_nxt  = i_bypass || (sub_r == ufc_pkg::OVS_LAST);
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_r      <= '0;
            sub_r      <= '0;
            o_tick     <= 1'b0;
            o_bit_tick <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            sub_r      <= sub_nxt;
            o_tick     <= tick_nxt;
            o_bit_tick <= bit_nxt;
        end
    end
endmodule // ufc_tick

// ### tb/ufc_top_asserts.sv
module ufc_top_asserts (
    input wire logic       I_CLK,
    input wire logic       I_RESET,
    input wire logic [7:0] I_DIVISOR_HIGH_BYTE,
    input wire logic [7:0] I_DIVISOR_LOW_BYTE,
    input wire logic       I_PRESCALE_BYPASS_BIT,
    input wire logic       I_INFRARED_EN,
    input wire logic       I_FLOW_EN,
    input wire logic       I_CTS_N,
    input wire logic       I_TX_IRQ_EN,
    input wire logic       I_RX_IRQ_EN,
    input wire logic       I_DMA_MODE,
    input wire logic       I_TX_WRITE,
    input wire logic       I_RX_READ,
    input wire logic       I_RXD,
    input wire logic       O_TXD,
    input wire logic       O_RTS_N,
    input wire logic       O_RXD_TIMER,
    input wire logic       O_RX_VALID,
    input wire logic       O_TX_ROOM,
    input wire logic       O_TX_IRQ,
    input wire logic       O_RX_IRQ,
    input wire logic       O_TX_DMA_REQ,
    input wire logic       O_RX_DMA_REQ
);
    // ****************************************
    // checks at the pins
    // ****************************************
    logic [7:0] cts_cnt_r;
    logic [7:0] cts_cnt_nxt;
    // only with one clock per sample is the bit time a fixed sixteen cycles
    wire slow = ({I_DIVISOR_HIGH_BYTE, I_DIVISOR_LOW_BYTE} <= 16'h0001)
                && !I_PRESCALE_BYPASS_BIT && !I_INFRARED_EN;
    always_comb cts_cnt_nxt = (I_FLOW_EN && I_CTS_N) ?
                              cts_cnt_r + {7'h00, cts_cnt_r != 8'hFF} : 8'h00;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) cts_cnt_r <= 8'h00;
        else cts_cnt_r <= cts_cnt_nxt;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    a_reset_idle_line: assert property ($fell(I_RESET) |-> O_TXD && O_TX_ROOM && !O_RX_VALID)
        else $error("line not idle after reset");
    a_bit_sixteen: assert property (slow && $fell(O_TXD) |-> !O_TXD[*8] ##1 !O_TXD[*8])
        else $error("low bit shorter than sixteen cycles");
    // a frame begun before the pause ends within 192 cycles
    a_cts_pause: assert property (slow && cts_cnt_r > 8'hC8 |-> !$fell(O_TXD))
        else $error("transmit started while paused");
    a_write_fills: assert property (I_TX_WRITE && O_TX_ROOM |=> !O_TX_ROOM)
        else $error("room stayed after write");
    a_tx_irq_mask: assert property (!I_TX_IRQ_EN ##1 !I_TX_IRQ_EN |-> !O_TX_IRQ)
        else $error("masked transmit irq");
    a_rx_irq_mask: assert property (!I_RX_IRQ_EN ##1 !I_RX_IRQ_EN |-> !O_RX_IRQ)
        else $error("masked receive irq");
    a_dma_gated: assert property (!I_DMA_MODE ##1 !I_DMA_MODE |-> !O_TX_DMA_REQ && !O_RX_DMA_REQ)
        else $error("dma request outside dma mode");
    a_rts_empty: assert property (!O_RX_VALID |-> !O_RTS_N)
        else $error("stop request with nothing held");
    a_rts_no_flow: assert property (!I_FLOW_EN ##1 !I_FLOW_EN |-> !O_RTS_N)
        else $error("stop request without flow control");
    a_timer_copy: assert property (1'b1 |=> O_RXD_TIMER == $past(I_RXD))
        else $error("timer copy differs from line");
    c_pop: cover property (O_RX_VALID && I_RX_READ);
    c_start: cover property ($fell(O_TXD));
    c_rts: cover property (O_RTS_N);
endmodule // ufc_top_asserts

bind ufc_top ufc_top_asserts i_ufc_top_asserts (.*);

// ### tb/ufc_far_end.sv
module ufc_far_end (
    input  wire logic       i_clk,
    input  wire logic       i_txd,
    input  wire logic [3:0] i_bits,
    output logic            o_rxd,
    output logic [11:0]     o_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // remote port: capture a frame, echo it
    // ****************************************
    logic [11:0] bits_r;
    initial begin
        o_rxd = 1'b1;
        o_seen = 12'h000;
        forever begin
            @(negedge i_txd);
            bits_r = 12'h000;
            repeat (8) @(posedge i_clk);
            for (int k = 0; k < int'(i_bits); k++) begin
                repeat (16) @(posedge i_clk);
                bits_r[k] = i_txd;
            end
            o_seen <= {bits_r[10:0], 1'b0};
            // low start, lsb first, high idle
            o_rxd <= 1'b0;
            repeat (16) @(posedge i_clk);
            for (int k = 0; k < int'(i_bits); k++) begin
                o_rxd <= bits_r[k];
                repeat (16) @(posedge i_clk);
            end
            o_rxd <= 1'b1;
        end
    end
endmodule // ufc_far_end

// ### tb/tb_top.sv
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_CLK = 1'b0, I_RESET = 1'b1, I_PRESCALE_BYPASS_BIT = 1'b0, I_PORT_ENABLE = 1'b1;
    logic [7:0] I_DIVISOR_HIGH_BYTE = 8'h00, I_DIVISOR_LOW_BYTE = 8'h01, I_TX_DATA = 8'h00;
    logic [1:0] I_WORD_LEN = 2'h3;
    logic I_TWO_STOP = 1'b0, I_PARITY_EN = 1'b0, I_PARITY_EVEN = 1'b0, I_INFRARED_EN = 1'b0;
    logic I_FLOW_EN = 1'b0, I_TX_IRQ_EN = 1'b1, I_RX_IRQ_EN = 1'b1, I_DMA_MODE = 1'b1;
    logic I_TX_WRITE = 1'b0, I_RX_READ = 1'b0, I_CTS_N = 1'b0;
    wire  I_RXD;
    logic O_TXD, O_RTS_N, O_RXD_TIMER, O_RX_VALID, O_RX_PARITY_ERR, O_RX_FRAME_ERR;
    logic O_RX_OVERRUN, O_TX_ROOM, O_TX_IRQ, O_RX_IRQ, O_TX_DMA_REQ, O_RX_DMA_REQ;
    logic [7:0] O_RX_DATA;
    logic [3:0] nbits = 4'h9;
    logic [11:0] seen;
    int failures = 0, comparisons = 0, cycles = 0;
    // {word len, two stop, parity on, even, data, expected char}
    logic [20:0] rows [5] = '{21'h001515, 21'h0B2A2A, 21'h165B5B, 21'h1FA7A7, 21'h18C3C3};
    ufc_top i_ufc_top (.*);
    ufc_far_end i_ufc_far_end (.i_clk(I_CLK), .i_txd(O_TXD), .i_bits(nbits), .o_rxd(I_RXD),
                               .o_seen(seen));
    always #50 I_CLK = ~I_CLK;
    // ceiling well above the roughly 4000 cycles the tests take
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task complete_run;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // line image including start bit; bits past the frame read as zero
    function logic [11:0] exp_line(input logic [12:0] r);
        logic [11:0] v;
        int nd;
        nd = 5 + r[12:11];
        v = 12'hFFE;
        for (int k = 0; k < nd; k++) v[k + 1] = r[k];
        if (r[9]) v[nd + 1] = r[8] ? ^r[7:0] : ~^r[7:0];
        return v & ((12'h002 << (nd + r[9] + r[10] + 1)) - 12'h001);
    endfunction
    task send(input logic [7:0] d);
        for (int i = 0; i < 50 && O_TX_ROOM !== 1'b1; i++) @(negedge I_CLK);
        I_TX_DATA = d;
        I_TX_WRITE = 1'b1;
        @(negedge I_CLK);
        I_TX_WRITE = 1'b0;
    endtask
    // the margin lets the far end finish its echo before the next start
    task wait_valid;
        for (int i = 0; i < 800 && O_RX_VALID !== 1'b1; i++) @(negedge I_CLK);
        repeat (20) @(negedge I_CLK);
    endtask
    task pop;
        I_RX_READ = 1'b1;
        @(negedge I_CLK);
        I_RX_READ = 1'b0;
        @(negedge I_CLK);
    endtask
    initial begin
        repeat (5) @(negedge I_CLK);
        I_RESET = 1'b0;
        `CHK("txd", 1'b1, O_TXD)
        `CHK("room", 1'b1, O_TX_ROOM)
        `CHK("rts_n", 1'b0, O_RTS_N)
        $display("test reset done");
        foreach (rows[i]) begin
            {I_WORD_LEN, I_TWO_STOP, I_PARITY_EN, I_PARITY_EVEN} = rows[i][20:16];
            nbits = 4'(6 + rows[i][20:19] + rows[i][17] + rows[i][18]);
            send(rows[i][15:8]);
            wait_valid();
            `CHK("line", exp_line(rows[i][20:8]), seen)
            `CHK("rx_data", rows[i][7:0], O_RX_DATA)
            `CHK("parity_err", 1'b0, O_RX_PARITY_ERR)
            `CHK("frame_err", 1'b0, O_RX_FRAME_ERR)
            `CHK("rx_irq", 1'b1, O_RX_IRQ)
            `CHK("rx_dma", 1'b1, O_RX_DMA_REQ)
            pop();
            $display("test row %0d done", i);
        end
        I_FLOW_EN = 1'b1;
        I_CTS_N = 1'b1;
        send(8'h3C);
        repeat (300) @(negedge I_CLK);
        `CHK("txd_paused", 1'b1, O_TXD)
        `CHK("room_paused", 1'b0, O_TX_ROOM)
        I_CTS_N = 1'b0;
        wait_valid();
        send(8'h96);
        for (int i = 0; i < 800 && O_RTS_N !== 1'b1; i++) @(negedge I_CLK);
        `CHK("rts_n_high", 1'b1, O_RTS_N)
        `CHK("head", 8'h3C, O_RX_DATA)
        pop();
        `CHK("second", 8'h96, O_RX_DATA)
        pop();
        `CHK("rts_n_low", 1'b0, O_RTS_N)
        `CHK("empty", 1'b0, O_RX_VALID)
        $display("test flow done");
        I_FLOW_EN = 1'b0;
        send(8'h11);
        repeat (500) @(negedge I_CLK);
        send(8'h22);
        repeat (500) @(negedge I_CLK);
        send(8'h33);
        repeat (500) @(negedge I_CLK);
        `CHK("overrun", 1'b1, O_RX_OVERRUN)
        `CHK("kept_head", 8'h11, O_RX_DATA)
        `CHK("rts_n_off", 1'b0, O_RTS_N)
        `CHK("tx_irq", 1'b1, O_TX_IRQ)
        `CHK("tx_dma", 1'b1, O_TX_DMA_REQ)
        I_TX_IRQ_EN = 1'b0;
        I_RX_IRQ_EN = 1'b0;
        I_DMA_MODE = 1'b0;
        repeat (2) @(negedge I_CLK);
        `CHK("tx_irq_masked", 1'b0, O_TX_IRQ)
        `CHK("rx_irq_masked", 1'b0, O_RX_IRQ)
        `CHK("tx_dma_off", 1'b0, O_TX_DMA_REQ)
        `CHK("rx_dma_off", 1'b0, O_RX_DMA_REQ)
        $display("test overrun and masks done");
        complete_run();
    end
endmodule // tb_top
